// [logic/clock_chip_global_control_regs.sv]
// Global control register bank: loop enables, VCO choice, channel pairs,
// sync pin handling, alarm latch and scratchpad, behind an APB slave.
// Assumes APB inputs and device status inputs are synchronous to sys_clk.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Operation
// - Global enable bit 5 turns SYSREF reseeding from the RF clock on.
// - VCO field 00 external/off, 01 high band, 10 low band.
// - Global enable bit 2 turns the SYSREF time reference on.
// - Global enable bit 1 is the master enable of the second loop.
// - Global enable bit 0 is the master enable of the first loop.
// - Pair-enable bit n enables output channels 2n and 2n+1.
// - Sync pin mode 00 ignores the pin.
// - Mode 01 carries a pin rising edge through the second loop.
// - Mode 10 turns a pin edge into a pulse-generator request.
// - Mode 11 aligns when an alarm exists, else requests pulses.
// - Mode bit 5 makes clock input one the external VCO input.
// - Mode bit 4 makes clock input zero the RF sync input.
// - Reference bit k enables clock input k for the first loop.
// - Alarm clear bit 0 clears all latched alarms.
// - Scratchpad stores and returns any byte, no other effect.
// - Lock-sync bit 0 clear: second loop aligns on lock.
// - Lock-sync bit 0 set: no alignment event on lock.
module clock_chip_global_control_regs (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device status
   input wire logic sync_pin,
   input wire logic second_loop_locked,
   input wire logic alarm_in,
   // Loop and reference control
   output logic first_loop_on,
   output logic second_loop_on,
   output logic rf_reseed_on,
   output logic sysref_time_ref_on,
   output logic high_band_vco_on,
   output logic low_band_vco_on,
   output logic ext_vco_sel,
   output logic [13:0] channel_on,
   output logic clock_input_one_ext_vco,
   output logic clock_input_zero_rf_sync,
   output logic [3:0] ref_path_on,
   // Alarm and events
   output logic alarm_clear_pulse,
   output logic alarms_latched,
   output logic align_event,
   output logic pulse_gen_req,
   output logic lock_align_event,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [13:0] pair_expand(input logic [6:0] pairs);
      logic [13:0] res;
      res = 14'h0000;
      for (int n = 0; n < gctl_pkg::PAIRS; n++) begin
         res[2*n] = pairs[n];
         res[2*n+1] = pairs[n];
      end
      return res;
   endfunction

   function automatic logic is_mapped(input logic [11:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      return (addr[1:0] == 2'h0) &&
         (((idx >= gctl_pkg::IDX_GLOBAL_EN) &&
         (idx <= gctl_pkg::IDX_LOCK_SYNC)) ||
         ((idx >= gctl_pkg::IDX_IRQ_STATUS) &&
         (idx <= gctl_pkg::IDX_IRQ_EN)));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0] ge_r;
   logic [7:0] pair_r;
   logic [7:0] mode_r;
   logic [7:0] alarm_clr_r;
   logic [7:0] misc_r;
   logic [7:0] scratch_r;
   logic [7:0] lock_r;
   logic [3:0] irq_en_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic alm_r;
   logic clr_pulse_r;
   logic [9:0] idx;
   logic wr_en;
   logic [31:0] rd_val;
   logic alarm_clr_now;

   event_if ev ();

   assign idx = paddr[11:2];
   // Write lands at the access edge; pready is high in every access cycle
   assign wr_en = psel & penable & pwrite & pready_r & pstrb[0] &
      is_mapped(paddr);
   assign alarm_clr_now = wr_en & (idx == gctl_pkg::IDX_ALARM_CLR) &
      pwdata[gctl_pkg::ALARM_CLR_BIT];

   ////////////////////////////////////////////////////////////////////////
   // APB handshake: one access cycle, data captured in setup

   always_comb begin
      case (idx)
         gctl_pkg::IDX_GLOBAL_EN: rd_val = {24'h000000, ge_r};
         gctl_pkg::IDX_PAIR_EN: rd_val = {24'h000000, pair_r};
         gctl_pkg::IDX_MODE: rd_val = {24'h000000, mode_r};
         gctl_pkg::IDX_ALARM_CLR: rd_val = {24'h000000, alarm_clr_r};
         gctl_pkg::IDX_MISC_RSVD: rd_val = {24'h000000, misc_r};
         gctl_pkg::IDX_SCRATCH: rd_val = {24'h000000, scratch_r};
         gctl_pkg::IDX_LOCK_SYNC: rd_val = {24'h000000, lock_r};
         gctl_pkg::IDX_IRQ_STATUS: rd_val = {28'h0000000, ev.status};
         gctl_pkg::IDX_IRQ_EN: rd_val = {28'h0000000, irq_en_r};
         default: rd_val = 32'h00000000;
      endcase
      if (!is_mapped(paddr)) begin
         rd_val = 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= psel & ~penable;
         pslverr_r <= psel & ~penable & ~is_mapped(paddr);
         if (psel && !penable && !pwrite) begin
            prdata_r <= rd_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ge_r <= gctl_pkg::RST_REG;
         pair_r <= gctl_pkg::RST_REG;
         mode_r <= gctl_pkg::RST_REG;
         alarm_clr_r <= gctl_pkg::RST_REG;
         misc_r <= gctl_pkg::RST_REG;
         scratch_r <= gctl_pkg::RST_REG;
         lock_r <= gctl_pkg::RST_REG;
         irq_en_r <= gctl_pkg::RST_EV;
      end else if (wr_en) begin
         case (idx)
            gctl_pkg::IDX_GLOBAL_EN: ge_r <= pwdata[7:0];
            gctl_pkg::IDX_PAIR_EN: pair_r <= pwdata[7:0];
            gctl_pkg::IDX_MODE: mode_r <= pwdata[7:0];
            gctl_pkg::IDX_ALARM_CLR: alarm_clr_r <= pwdata[7:0];
            gctl_pkg::IDX_MISC_RSVD: misc_r <= pwdata[7:0];
            gctl_pkg::IDX_SCRATCH: scratch_r <= pwdata[7:0];
            gctl_pkg::IDX_LOCK_SYNC: lock_r <= pwdata[7:0];
            gctl_pkg::IDX_IRQ_EN: irq_en_r <= pwdata[3:0];
            default: irq_en_r <= irq_en_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Alarm latch: a live alarm beats the clear so it cannot be lost

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alm_r <= 1'b0;
         clr_pulse_r <= 1'b0;
      end else begin
         alm_r <= alarm_in | (alm_r & ~alarm_clr_now);
         clr_pulse_r <= alarm_clr_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered control outputs, one cycle behind the registers

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         first_loop_on <= 1'b0;
         second_loop_on <= 1'b0;
         rf_reseed_on <= 1'b0;
         sysref_time_ref_on <= 1'b0;
         channel_on <= 14'h0000;
         clock_input_one_ext_vco <= 1'b0;
         clock_input_zero_rf_sync <= 1'b0;
         ref_path_on <= 4'h0;
      end else begin
         first_loop_on <= ge_r[gctl_pkg::GE_LOOP1];
         second_loop_on <= ge_r[gctl_pkg::GE_LOOP2];
         rf_reseed_on <= ge_r[gctl_pkg::GE_RESEED];
         sysref_time_ref_on <= ge_r[gctl_pkg::GE_SYSREF];
         channel_on <= pair_expand(pair_r[6:0]);
         clock_input_one_ext_vco <= mode_r[gctl_pkg::MODE_CLOCK_INPUT_ONE_VCO];
         clock_input_zero_rf_sync <= mode_r[gctl_pkg::MODE_CLOCK_INPUT_ZERO_RF];
         ref_path_on <= mode_r[3:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         high_band_vco_on <= 1'b0;
         low_band_vco_on <= 1'b0;
         ext_vco_sel <= 1'b1;
      end else begin
         high_band_vco_on <= 1'b0;
         low_band_vco_on <= 1'b0;
         ext_vco_sel <= 1'b0;
         case (ge_r[gctl_pkg::GE_VCO_LSB +: 2])
            gctl_pkg::VCO_HIGH: high_band_vco_on <= 1'b1;
            gctl_pkg::VCO_LOW: low_band_vco_on <= 1'b1;
            default: ext_vco_sel <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event helpers; pin events are dropped while the second loop is off

   assign ev.sync_mode = mode_r[gctl_pkg::MODE_SYNC_LSB +: 2];
   assign ev.loop2_en = ge_r[gctl_pkg::GE_LOOP2];
   assign ev.no_align = lock_r[gctl_pkg::NO_ALIGN_BIT];
   assign ev.alarm_present = alm_r;
   assign ev.pin = sync_pin;
   assign ev.locked = second_loop_locked;
   assign ev.alarm_ev = alarm_in & ~alm_r;
   assign ev.irq_en = irq_en_r;
   assign ev.clr_wr = wr_en & (idx == gctl_pkg::IDX_IRQ_CLEAR);
   assign ev.clr_bits = pwdata[3:0];

   sync_event_gen u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .ev(ev)
   );

   irq_status u_irq (
      .sys_clk(sys_clk),
      .rst(rst),
      .ev(ev)
   );

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign alarm_clear_pulse = clr_pulse_r;
   assign alarms_latched = alm_r;
   assign align_event = ev.sync_ev;
   assign pulse_gen_req = ev.pulse_ev;
   assign lock_align_event = ev.lock_ev;
   assign irq = ev.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   logic wr_ge;
   assign wr_ge = wr_en && (idx == gctl_pkg::IDX_GLOBAL_EN);

   reseed_on_a: assert property (
      wr_ge |-> ##2 rf_reseed_on == $past(pwdata[5], 2))
      else $error("reseed enable does not follow write");
   vco_high_a: assert property (
      high_band_vco_on == ($past(ge_r[4:3]) == 2'h1) &&
      low_band_vco_on == ($past(ge_r[4:3]) == 2'h2))
      else $error("VCO band select wrong");
   sysref_ref_a: assert property (
      wr_ge |-> ##2 sysref_time_ref_on == $past(pwdata[2], 2))
      else $error("SYSREF time reference wrong");
   loop2_en_a: assert property (
      wr_ge |-> ##2 second_loop_on == $past(pwdata[1], 2))
      else $error("second loop enable wrong");
   loop1_en_a: assert property (
      wr_ge |-> ##2 first_loop_on == $past(pwdata[0], 2))
      else $error("first loop enable wrong");
   chan_pair_a: assert property (
      channel_on == pair_expand($past(pair_r[6:0])))
      else $error("channel pair enables wrong");
   sync_off_a: assert property (
      mode_r[7:6] == 2'h0 |=> !align_event && !pulse_gen_req)
      else $error("sync pin not ignored");
   sync_align_a: assert property (
      mode_r[7:6] == 2'h1 && $rose(sync_pin) && ge_r[1] |=> align_event)
      else $error("sync edge not carried");
   pulse_req_a: assert property (
      mode_r[7:6] == 2'h2 && $rose(sync_pin) && ge_r[1]
      |=> pulse_gen_req && !align_event)
      else $error("pulse request missing");
   auto_mode_a: assert property (
      mode_r[7:6] == 2'h3 && $rose(sync_pin) && ge_r[1]
      |=> align_event == $past(alm_r) && pulse_gen_req == !$past(alm_r))
      else $error("auto sync mode wrong");
   ext_vco_in_a: assert property (
      clock_input_one_ext_vco == $past(mode_r[5]))
      else $error("input one VCO mode wrong");
   rf_sync_in_a: assert property (
      clock_input_zero_rf_sync == $past(mode_r[4]))
      else $error("input zero RF sync wrong");
   ref_path_a: assert property (
      ref_path_on == $past(mode_r[3:0]))
      else $error("reference path enables wrong");
   alarm_clear_a: assert property (
      alarm_clr_now && !alarm_in |=> !alarms_latched && alarm_clear_pulse)
      else $error("alarms not cleared");
   scratch_keep_a: assert property (
      wr_en && idx == gctl_pkg::IDX_SCRATCH |=>
      scratch_r == $past(pwdata[7:0]))
      else $error("scratchpad lost data");
   lock_align_a: assert property (
      $rose(second_loop_locked) && !lock_r[0] && ge_r[1] |=> lock_align_event)
      else $error("no align event on lock");
   lock_quiet_a: assert property (
      lock_r[0] |=> !lock_align_event)
      else $error("align event while suppressed");
   vco_code3_a: assert property (
      $past(ge_r[4:3]) == 2'h3 |-> ext_vco_sel && !high_band_vco_on &&
      !low_band_vco_on)
      else $error("code 11 not treated as off");

endmodule // clock_chip_global_control_regs

// [logic/irq_status.sv]
// Sticky event status with enable mask and one level interrupt.
// Assumes event pulses and clear strobes are synchronous to sys_clk.
`timescale 1ns/1ps
module irq_status (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Event bundle
   event_if.irqs ev
);
   logic [3:0] set_v;
   logic [3:0] status_r;
   logic [3:0] status_nxt;
   logic irq_r;

   always_comb begin
      set_v = gctl_pkg::RST_EV;
      set_v[gctl_pkg::EV_SYNC] = ev.sync_ev;
      set_v[gctl_pkg::EV_PULSE] = ev.pulse_ev;
      set_v[gctl_pkg::EV_LOCK] = ev.lock_ev;
      set_v[gctl_pkg::EV_ALARM] = ev.alarm_ev;
      // A new event beats a clear in the same cycle
      status_nxt = status_r & ~(ev.clr_wr ? ev.clr_bits : 4'h0);
      status_nxt = status_nxt | set_v;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_r <= gctl_pkg::RST_EV;
         irq_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         irq_r <= |(status_nxt & ev.irq_en);
      end
   end

   assign ev.status = status_r;
   assign ev.irq = irq_r;
endmodule // irq_status

// [logic/sync_event_gen.sv]
// Turns sync pin edges and loop lock into one-cycle event pulses.
// Assumes pin and lock inputs are already synchronous to sys_clk.
`timescale 1ns/1ps
module sync_event_gen (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Event bundle
   event_if.gen ev
);
   logic pin_q_r;
   logic lock_q_r;
   logic pin_rise;
   logic lock_rise;

   assign pin_rise = ev.pin & ~pin_q_r & ev.loop2_en;
   assign lock_rise = ev.locked & ~lock_q_r & ev.loop2_en;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_q_r <= 1'b0;
         lock_q_r <= 1'b0;
      end else begin
         pin_q_r <= ev.pin;
         lock_q_r <= ev.locked;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ev.sync_ev <= 1'b0;
         ev.pulse_ev <= 1'b0;
      end else begin
         ev.sync_ev <= 1'b0;
         ev.pulse_ev <= 1'b0;
         if (pin_rise) begin
            case (ev.sync_mode)
               gctl_pkg::SYNC_ALIGN: ev.sync_ev <= 1'b1;
               gctl_pkg::SYNC_PULSE: ev.pulse_ev <= 1'b1;
               gctl_pkg::SYNC_AUTO: begin
                  ev.sync_ev <= ev.alarm_present;
                  ev.pulse_ev <= ~ev.alarm_present;
               end
               default: ev.sync_ev <= 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ev.lock_ev <= 1'b0;
      end else begin
         ev.lock_ev <= lock_rise & ~ev.no_align;
      end
   end
endmodule // sync_event_gen

// [pkg/event_if.sv]
// Bundle between the register bank and its event and interrupt helpers.
// Assumes one clock domain; all signals change after sys_clk edges.
`timescale 1ns/1ps
interface event_if;
   logic [1:0] sync_mode;
   logic loop2_en;
   logic no_align;
   logic alarm_present;
   logic pin;
   logic locked;
   logic sync_ev;
   logic pulse_ev;
   logic lock_ev;
   logic alarm_ev;
   logic [3:0] irq_en;
   logic clr_wr;
   logic [3:0] clr_bits;
   logic [3:0] status;
   logic irq;
   modport gen (input sync_mode, loop2_en, no_align, alarm_present, pin,
      locked, output sync_ev, pulse_ev, lock_ev);
   modport irqs (input sync_ev, pulse_ev, lock_ev, alarm_ev, irq_en,
      clr_wr, clr_bits, output status, irq);
endinterface

// [pkg/gctl_pkg.sv]
// Constants for the global control register bank of the clock chip.
// Assumes a 32-bit APB slave with word-aligned registers.
package gctl_pkg;

   // Bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 10;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_GLOBAL_EN = 10'h003;
   localparam logic [9:0] IDX_PAIR_EN = 10'h004;
   localparam logic [9:0] IDX_MODE = 10'h005;
   localparam logic [9:0] IDX_ALARM_CLR = 10'h006;
   localparam logic [9:0] IDX_MISC_RSVD = 10'h007;
   localparam logic [9:0] IDX_SCRATCH = 10'h008;
   localparam logic [9:0] IDX_LOCK_SYNC = 10'h009;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h070;
   localparam logic [9:0] IDX_IRQ_CLEAR = 10'h071;
   localparam logic [9:0] IDX_IRQ_EN = 10'h072;

   // Field positions
   localparam int GE_RESEED = 5;
   localparam int GE_VCO_LSB = 3;
   localparam int GE_SYSREF = 2;
   localparam int GE_LOOP2 = 1;
   localparam int GE_LOOP1 = 0;
   localparam int MODE_SYNC_LSB = 6;
   localparam int MODE_CLOCK_INPUT_ONE_VCO = 5;
   localparam int MODE_CLOCK_INPUT_ZERO_RF = 4;
   localparam int ALARM_CLR_BIT = 0;
   localparam int NO_ALIGN_BIT = 0;
   localparam int PAIRS = 7;
   localparam int CHANNELS = 14;
   localparam int REF_PATHS = 4;

   // Values after reset
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [3:0] RST_EV = 4'h0;

   // VCO selection codes
   localparam logic [1:0] VCO_EXT = 2'h0;
   localparam logic [1:0] VCO_HIGH = 2'h1;
   localparam logic [1:0] VCO_LOW = 2'h2;

   // Sync pin modes
   localparam logic [1:0] SYNC_OFF = 2'h0;
   localparam logic [1:0] SYNC_ALIGN = 2'h1;
   localparam logic [1:0] SYNC_PULSE = 2'h2;
   localparam logic [1:0] SYNC_AUTO = 2'h3;

   // Interrupt event bits
   localparam int EV_W = 4;
   localparam int EV_SYNC = 0;
   localparam int EV_PULSE = 1;
   localparam int EV_LOCK = 2;
   localparam int EV_ALARM = 3;

endpackage

// [tb/test_clock_chip_global_control_regs.sv]
// Self-checking bench for the global control register bank.
// Assumes the bank answers APB with its own pready; waits are bounded.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_clock_chip_global_control_regs;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, ref_path_on;
   logic sync_pin, second_loop_locked, alarm_in, err, irq;
   logic first_loop_on, second_loop_on, rf_reseed_on, sysref_time_ref_on;
   logic high_band_vco_on, low_band_vco_on, ext_vco_sel;
   logic [13:0] channel_on;
   logic clock_input_one_ext_vco, clock_input_zero_rf_sync;
   logic alarm_clear_pulse, alarms_latched, align_event, pulse_gen_req;
   logic lock_align_event;
   logic [7:0] d;
   int n_fail = 0, comparisons = 0, n_al = 0, n_pg = 0, n_lk = 0, n_cp = 0;

   clock_chip_global_control_regs DUT (.sys_clk, .rst, .paddr, .psel,
      .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .sync_pin, .second_loop_locked, .alarm_in, .first_loop_on,
      .second_loop_on, .rf_reseed_on, .sysref_time_ref_on, .high_band_vco_on,
      .low_band_vco_on, .ext_vco_sel, .channel_on, .clock_input_one_ext_vco,
      .clock_input_zero_rf_sync, .ref_path_on, .alarm_clear_pulse,
      .alarms_latched, .align_event, .pulse_gen_req, .lock_align_event, .irq);

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Pulses are counted at the falling edge, where they have settled
   always @(negedge sys_clk) begin
      if (align_event === 1'b1) n_al++;
      if (pulse_gen_req === 1'b1) n_pg++;
      if (lock_align_event === 1'b1) n_lk++;
      if (alarm_clear_pulse === 1'b1) n_cp++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Pready is sampled at the rising edge; that same edge ends the access
   task automatic bus(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= {idx, 2'b00};
      pwrite <= w;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] v);
      bus(1'b1, idx, {24'h000000, v});
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] v);
      bus(1'b0, idx, 32'h00000000);
      `CHK(rd, {24'h000000, v})
      `CHK(err, 1'b0)
   endtask

   task automatic pin_ev(input int ea, input int ep);
      int a, p;
      a = n_al;
      p = n_pg;
      @(posedge sys_clk);
      sync_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sync_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK(n_al - a, ea)
      `CHK(n_pg - p, ep)
   endtask

   task automatic lock_ev(input int el);
      int l;
      l = n_lk;
      @(posedge sys_clk);
      second_loop_locked <= 1'b1;
      repeat (4) @(posedge sys_clk);
      second_loop_locked <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK(n_lk - l, el)
   endtask

   function automatic logic [13:0] pairs(input logic [6:0] p);
      logic [13:0] c;
      for (int n = 0; n < 7; n++) c[2*n+:2] = {2{p[n]}};
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, sync_pin, second_loop_locked, alarm_in} = '0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hf;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      `CHK(ext_vco_sel, 1'b1)
      for (int i = 3; i < 10; i++) rd_chk(10'(i), 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = {2'b00, i[2], i[1:0], ~i[2], i[0], ~i[0]};
         wr(gctl_pkg::IDX_GLOBAL_EN, d);
         `CHK(rf_reseed_on, d[5])
         `CHK(high_band_vco_on, d[4:3] == 2'h1)
         `CHK(low_band_vco_on, d[4:3] == 2'h2)
         `CHK(ext_vco_sel, d[4:3] == 2'h0 || d[4:3] == 2'h3)
         `CHK(sysref_time_ref_on, d[2])
         `CHK(second_loop_on, d[1])
         `CHK(first_loop_on, d[0])
         rd_chk(gctl_pkg::IDX_GLOBAL_EN, d);
      end
      for (int i = 0; i < 8; i++) begin
         d = (i < 7) ? 8'(1 << i) : 8'h55;
         wr(gctl_pkg::IDX_PAIR_EN, d);
         `CHK(channel_on, pairs(d[6:0]))
      end
      for (int k = 0; k < 4; k++) begin
         d = {2'b00, k[0], k[1], 4'(1 << k)};
         wr(gctl_pkg::IDX_MODE, d);
         `CHK(clock_input_one_ext_vco, d[5])
         `CHK(clock_input_zero_rf_sync, d[4])
         `CHK(ref_path_on, d[3:0])
      end
      wr(gctl_pkg::IDX_SCRATCH, 8'ha5);
      rd_chk(gctl_pkg::IDX_SCRATCH, 8'ha5);
      @(posedge sys_clk);
      pstrb <= 4'he;
      wr(gctl_pkg::IDX_SCRATCH, 8'h5a);
      @(posedge sys_clk);
      pstrb <= 4'hf;
      rd_chk(gctl_pkg::IDX_SCRATCH, 8'ha5);
      wr(gctl_pkg::IDX_MISC_RSVD, 8'h3c);
      rd_chk(gctl_pkg::IDX_MISC_RSVD, 8'h3c);
      bus(1'b0, 10'h00a, 32'h00000000);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h00000000)
      // Events: loop off, then each pin mode in turn
      wr(gctl_pkg::IDX_GLOBAL_EN, 8'h00);
      wr(gctl_pkg::IDX_MODE, 8'h40);
      pin_ev(0, 0);
      wr(gctl_pkg::IDX_GLOBAL_EN, 8'h02);
      wr(gctl_pkg::IDX_MODE, 8'h00);
      pin_ev(0, 0);
      wr(gctl_pkg::IDX_IRQ_EN, 8'h00);
      wr(gctl_pkg::IDX_IRQ_CLEAR, 8'h0f);
      wr(gctl_pkg::IDX_MODE, 8'h40);
      pin_ev(1, 0);
      rd_chk(gctl_pkg::IDX_IRQ_STATUS, 8'h01);
      `CHK(irq, 1'b0)
      wr(gctl_pkg::IDX_IRQ_EN, 8'h01);
      `CHK(irq, 1'b1)
      wr(gctl_pkg::IDX_IRQ_STATUS, 8'h00);
      rd_chk(gctl_pkg::IDX_IRQ_STATUS, 8'h01);
      wr(gctl_pkg::IDX_IRQ_CLEAR, 8'h01);
      `CHK(irq, 1'b0)
      rd_chk(gctl_pkg::IDX_IRQ_STATUS, 8'h00);
      wr(gctl_pkg::IDX_MODE, 8'h80);
      pin_ev(0, 1);
      wr(gctl_pkg::IDX_MODE, 8'hc0);
      pin_ev(0, 1);
      @(posedge sys_clk);
      alarm_in <= 1'b1;
      repeat (2) @(posedge sys_clk);
      alarm_in <= 1'b0;
      repeat (3) @(negedge sys_clk);
      `CHK(alarms_latched, 1'b1)
      pin_ev(1, 0);
      d = 8'(n_cp);
      wr(gctl_pkg::IDX_ALARM_CLR, 8'h01);
      `CHK(alarms_latched, 1'b0)
      `CHK(8'(n_cp) - d, 8'h01)
      wr(gctl_pkg::IDX_LOCK_SYNC, 8'h00);
      lock_ev(1);
      wr(gctl_pkg::IDX_LOCK_SYNC, 8'h01);
      lock_ev(0);
      wrap_up();
   end
endmodule // test_clock_chip_global_control_regs
